/* File: logic/psseq_pkg.sv */
package psseq_pkg;

  // Sequenced items: 14 converters and regulators, then clock output and power enable
  localparam int NITEM = 16;
  localparam int NREG = 14;
  localparam int OFFREG_BIT = 13;
  localparam int CLOCK_OUTPUT_BIT = 14;
  localparam int EXT_POWER_ENABLE_BIT = 15;
  localparam logic [15:0] REG_MASK = 16'h3FFF;
  localparam logic [15:0] OFFREG_MASK = 16'h2000;

  // Slot codes: 0 means no slot, 1 to 5 select a timeslot
  localparam logic [2:0] SLOT_NONE = 3'h0;
  localparam logic [2:0] SLOT_FIRST = 3'h1;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLOT_MIRROR = 3'h6;

  // System status register
  localparam logic [15:0] SYSTEM_STATUS_OFFSET = 16'h400D;
  localparam logic [15:0] SYSTEM_STATUS_RESET = 16'h0000;
  localparam int STATE_LSB = 0;
  localparam int STATE_W = 5;

  // Transition delay selector codes
  localparam logic [1:0] DLY_SEL_RESET = 2'h2;
  localparam logic [1:0] DLY_SEL_1MS = 2'h2;
  localparam logic [1:0] DLY_SEL_10MS = 2'h3;

  // Timing, in the printed units, and derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int SLOT_TIME_US = 2000;
  localparam int DLY_SHORT_US = 1000;
  localparam int DLY_LONG_US = 10000;
  localparam int FAIL_TIME_MS = 2000;
  localparam int SLOT_CYCLES = SLOT_TIME_US * CLK_MHZ;
  localparam int DLY_SHORT_CYCLES = DLY_SHORT_US * CLK_MHZ;
  localparam int DLY_LONG_CYCLES = DLY_LONG_US * CLK_MHZ;
  localparam int FAIL_CYCLES = FAIL_TIME_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int FAIL_W = 28;

  // Main state; status readback shows these codes directly
  typedef enum logic [4:0] {
    ST_OFF      = 5'h00,
    ST_NOPWR    = 5'h01,
    ST_BACKUP   = 5'h02,
    ST_PROG     = 5'h0B,
    ST_SEQ_ON   = 5'h10,
    ST_SEQ_OFF  = 5'h11,
    ST_SEQ_SLP  = 5'h12,
    ST_SEQ_WAKE = 5'h13,
    ST_DLY_OFF  = 5'h14,
    ST_DLY_SLP  = 5'h15,
    ST_DLY_WAKE = 5'h16,
    ST_SLEEP    = 5'h1C,
    ST_ON       = 5'h1F
  } psseq_state_t;

  typedef logic [NITEM-1:0][2:0] psseq_slots_t;

  typedef struct packed {
    logic prog_exit;
    logic prog_enter;
    logic wake;
    logic sleep;
    logic off;
    logic on;
  } psseq_evt_t;

  typedef struct packed {
    logic por_ok;
    logic dev_ok;
    logic sys_ok;
  } psseq_supply_t;

  typedef struct packed {
    logic [1:0] delay_sel;
    logic off_reg_keep;
    logic unclocked_backup;
    logic boost_sw_en;
  } psseq_cfg_t;

  typedef struct packed {
    logic backup;
    logic sleep;
    logic on;
    logic off;
  } psseq_trans_t;

endpackage

/* File: logic/psseq_sync.sv */
`timescale 1ns/10ps

module psseq_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage is read by the second stage only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

/* File: logic/psseq_top.sv */
`timescale 1ns/10ps

// Contract
// - Six main power states are implemented
// - No power: everything disabled, registers lost
// - Off: RTC runs, reset low, regulators off except item 13 when off_reg_keep is set
// - Sleep entry and exit run configured sequence
// - Backup: all off, keep RTC, oscillator, scratch
// - Selectable unclocked backup freezes the RTC
// - Core supply below POR means no power
// - Core supply below reset threshold means backup
// - Off from sleep disables everything at once except item 13 when off_reg_keep is set
// - Five-bit state readback with fixed codes
// - Flag completed entry to backup/sleep/on/off
// - Sequences are five slots of 2ms
// - Slot waits for selected items' power good
// - Off, sleep, wake wait the transition delay
// - Regulators take one on-sequence slot each
// - Clock output and power enables slot too
// - On sequence needs supply above threshold
// - Off sequence reverses on-sequence slots
// - Sleep sequence disables items in sleep slots
// - Wake re-enables sleep-slot items in reverse
// - Delay selector: 2 bits, reset 10, 1ms/10ms
// - On sequence over 2s forces failed off
// - Off event drops unslotted regulators immediately, except item 13 when off_reg_keep is set
module psseq_top #(
  parameter int SLOT_CYCLES = psseq_pkg::SLOT_CYCLES,
  parameter int DLY_SHORT_CYCLES = psseq_pkg::DLY_SHORT_CYCLES,
  parameter int DLY_LONG_CYCLES = psseq_pkg::DLY_LONG_CYCLES,
  parameter int FAIL_CYCLES = psseq_pkg::FAIL_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Supply comparators and event pins, asynchronous
  input wire psseq_pkg::psseq_supply_t supply_i,
  input wire psseq_pkg::psseq_evt_t evt_i,
  input wire logic [psseq_pkg::NITEM-1:0] pgood_i,
  // Configuration from the register map, same clock
  input wire psseq_pkg::psseq_cfg_t cfg_i,
  input wire psseq_pkg::psseq_slots_t on_slot_i,
  input wire psseq_pkg::psseq_slots_t sleep_slot_i,
  input wire logic [psseq_pkg::NITEM-1:0] sw_en_i,
  // Enables toward regulators, clock output and power-enable pins
  output logic [psseq_pkg::NITEM-1:0] item_en_o,
  output logic boost_en_o,
  // Always-on domain controls
  output logic reset_out_n_o,
  output logic rtc_run_o,
  output logic osc_run_o,
  output logic func_reset_o,
  // Status and transition flags
  output logic [15:0] system_status_o,
  output psseq_pkg::psseq_trans_t trans_o,
  output logic seq_fail_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Items assigned to a given slot in a slot table
  function automatic logic [psseq_pkg::NITEM-1:0] slot_mask(
    input psseq_pkg::psseq_slots_t tbl,
    input logic [2:0] slot
  );
    logic [psseq_pkg::NITEM-1:0] m;
    m = '0;
    for (int i = 0; i < psseq_pkg::NITEM; i++) begin
      m[i] = (tbl[i] == slot);
    end
    return m;
  endfunction

  // Items holding any slot in a slot table
  function automatic logic [psseq_pkg::NITEM-1:0] slotted(
    input psseq_pkg::psseq_slots_t tbl
  );
    logic [psseq_pkg::NITEM-1:0] m;
    m = '0;
    for (int i = 0; i < psseq_pkg::NITEM; i++) begin
      m[i] = (tbl[i] != psseq_pkg::SLOT_NONE);
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  localparam int SYNC_W = 3 + 6 + psseq_pkg::NITEM;

  logic [SYNC_W-1:0] sync_w;
  psseq_pkg::psseq_supply_t sup_s;
  psseq_pkg::psseq_supply_t sup_low_s;
  psseq_pkg::psseq_evt_t evt_s;
  logic [psseq_pkg::NITEM-1:0] pgood_s;

  psseq_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({~supply_i, evt_i, pgood_i}),
    .sync_o(sync_w)
  );

  // Supplies cross inverted, so a cleared synchroniser reads as healthy after reset
  assign {sup_low_s, evt_s, pgood_s} = sync_w;
  assign sup_s = ~sup_low_s;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  psseq_pkg::psseq_state_t state_reg, state_next;
  psseq_pkg::psseq_evt_t evt_prev_reg;
  logic [2:0] slot_reg, slot_next;
  logic [psseq_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [psseq_pkg::FAIL_W-1:0] fail_cnt_reg, fail_cnt_next;
  logic [psseq_pkg::NITEM-1:0] en_reg, en_next;
  logic fail_reg, fail_next;
  logic boost_reg;
  logic reset_out_n_reg;
  logic rtc_run_reg;
  logic osc_run_reg;
  logic func_reset_reg;
  logic [15:0] status_reg;
  psseq_pkg::psseq_trans_t trans_reg, trans_next;

  ////////////////////////////////////////////////////////////////////////////
  // Event edges and sequence decode

  psseq_pkg::psseq_evt_t evt_p;
  assign evt_p = evt_s & ~evt_prev_reg;

  wire seq_on = (state_reg == psseq_pkg::ST_SEQ_ON);
  wire seq_off = (state_reg == psseq_pkg::ST_SEQ_OFF);
  wire seq_slp = (state_reg == psseq_pkg::ST_SEQ_SLP);
  wire seq_wake = (state_reg == psseq_pkg::ST_SEQ_WAKE);
  wire seq_active = seq_on | seq_off | seq_slp | seq_wake;
  wire seq_enable = seq_on | seq_wake;
  wire seq_reverse = seq_off | seq_wake;
  wire seq_sleep_tbl = seq_slp | seq_wake;

  wire [2:0] cur_slot = seq_reverse ? 3'(psseq_pkg::SLOT_MIRROR - slot_reg) : slot_reg;
  wire psseq_pkg::psseq_slots_t cur_tbl = seq_sleep_tbl ? sleep_slot_i : on_slot_i;
  wire [psseq_pkg::NITEM-1:0] cur_mask = slot_mask(cur_tbl, cur_slot);

  // Only converters and regulators report power good; logic outputs need no wait
  wire [psseq_pkg::NITEM-1:0] wait_mask = cur_mask & psseq_pkg::REG_MASK;
  wire pgood_met = !seq_enable || ((pgood_s & wait_mask) == wait_mask);
  wire slot_time_up = (cnt_reg >= psseq_pkg::CNT_W'(SLOT_CYCLES - 1));
  wire slot_done = seq_active && slot_time_up && pgood_met;
  wire seq_done = slot_done && (slot_reg == psseq_pkg::SLOT_LAST);

  // Delay before off, sleep and wake sequences
  wire [psseq_pkg::CNT_W-1:0] dly_target =
    (cfg_i.delay_sel == psseq_pkg::DLY_SEL_10MS) ? psseq_pkg::CNT_W'(DLY_LONG_CYCLES) :
    (cfg_i.delay_sel == psseq_pkg::DLY_SEL_1MS) ? psseq_pkg::CNT_W'(DLY_SHORT_CYCLES) :
    '0;
  wire dly_done = (cnt_reg >= dly_target);

  wire fail_hit = seq_on && (fail_cnt_reg >= psseq_pkg::FAIL_W'(FAIL_CYCLES - 1));

  wire [psseq_pkg::NITEM-1:0] on_slotted = slotted(on_slot_i);
  wire [psseq_pkg::NITEM-1:0] off_keep =
    cfg_i.off_reg_keep ? psseq_pkg::OFFREG_MASK : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Main state machine

  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    cnt_next = cnt_reg + psseq_pkg::CNT_W'(1);
    fail_cnt_next = '0;
    en_next = en_reg;
    fail_next = fail_reg;
    case (state_reg)
      psseq_pkg::ST_NOPWR: begin
        state_next = psseq_pkg::ST_OFF;
        en_next = '0;
        fail_next = 1'b0;
      end
      psseq_pkg::ST_BACKUP: begin
        en_next = '0;
        fail_next = 1'b0;
        state_next = psseq_pkg::ST_OFF;
      end
      psseq_pkg::ST_OFF: begin
        en_next = off_keep;
        if (evt_p.prog_enter) begin
          state_next = psseq_pkg::ST_PROG;
        end else if (evt_p.on && sup_s.sys_ok) begin
          // On sequence starts without any transition delay
          state_next = psseq_pkg::ST_SEQ_ON;
          slot_next = psseq_pkg::SLOT_FIRST;
          cnt_next = '0;
          fail_next = 1'b0;
        end
      end
      psseq_pkg::ST_PROG: begin
        en_next = '0;
        if (evt_p.prog_exit) begin
          state_next = psseq_pkg::ST_OFF;
        end
      end
      psseq_pkg::ST_ON: begin
        // Unslotted items stay under software enable while on
        en_next = (en_reg & on_slotted) | (sw_en_i & ~on_slotted);
        if (evt_p.off) begin
          state_next = psseq_pkg::ST_DLY_OFF;
          en_next = en_reg & (on_slotted | off_keep);
          cnt_next = '0;
        end else if (evt_p.sleep) begin
          state_next = psseq_pkg::ST_DLY_SLP;
          cnt_next = '0;
        end
      end
      psseq_pkg::ST_SLEEP: begin
        if (evt_p.off) begin
          state_next = psseq_pkg::ST_OFF;
          en_next = off_keep;
        end else if (evt_p.wake) begin
          state_next = psseq_pkg::ST_DLY_WAKE;
          cnt_next = '0;
        end
      end
      psseq_pkg::ST_DLY_OFF, psseq_pkg::ST_DLY_SLP, psseq_pkg::ST_DLY_WAKE: begin
        if (dly_done) begin
          slot_next = psseq_pkg::SLOT_FIRST;
          cnt_next = '0;
          if (state_reg == psseq_pkg::ST_DLY_OFF) begin
            state_next = psseq_pkg::ST_SEQ_OFF;
          end else if (state_reg == psseq_pkg::ST_DLY_SLP) begin
            state_next = psseq_pkg::ST_SEQ_SLP;
          end else begin
            state_next = psseq_pkg::ST_SEQ_WAKE;
          end
        end
      end
      psseq_pkg::ST_SEQ_ON, psseq_pkg::ST_SEQ_OFF,
      psseq_pkg::ST_SEQ_SLP, psseq_pkg::ST_SEQ_WAKE: begin
        // Events are not looked at here, so only the failure timeout or a supply drop ends a sequence early
        fail_cnt_next = fail_cnt_reg + psseq_pkg::FAIL_W'(1);
        if (seq_enable) begin
          en_next = en_reg | cur_mask;
        end else begin
          en_next = en_reg & ~cur_mask;
        end
        if (fail_hit) begin
          state_next = psseq_pkg::ST_OFF;
          en_next = '0;
          fail_next = 1'b1;
        end else if (slot_done) begin
          cnt_next = '0;
          slot_next = slot_reg + 3'h1;
          if (seq_done) begin
            if (seq_on || seq_wake) begin
              state_next = psseq_pkg::ST_ON;
            end else if (seq_slp) begin
              state_next = psseq_pkg::ST_SLEEP;
            end else begin
              state_next = psseq_pkg::ST_OFF;
            end
          end
        end
      end
      default: begin
        state_next = psseq_pkg::ST_OFF;
        en_next = '0;
      end
    endcase
    // Supply thresholds override everything else
    if (!sup_s.por_ok) begin
      state_next = psseq_pkg::ST_NOPWR;
      en_next = '0;
      fail_next = 1'b0;
    end else if (!sup_s.dev_ok) begin
      state_next = psseq_pkg::ST_BACKUP;
      en_next = '0;
    end
  end

  // Completed arrival in a settled state
  wire entering = (state_next != state_reg);
  always_comb begin
    trans_next.backup = entering && (state_next == psseq_pkg::ST_BACKUP);
    trans_next.sleep = entering && (state_next == psseq_pkg::ST_SLEEP);
    trans_next.on = entering && (state_next == psseq_pkg::ST_ON);
    trans_next.off = entering && (state_next == psseq_pkg::ST_OFF);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output decode

  // Reset pin held low until the on sequence has completed
  wire rst_out_next = !(state_next inside {psseq_pkg::ST_OFF, psseq_pkg::ST_NOPWR,
    psseq_pkg::ST_BACKUP, psseq_pkg::ST_PROG, psseq_pkg::ST_SEQ_ON});
  wire rtc_next = (state_next == psseq_pkg::ST_BACKUP) ? !cfg_i.unclocked_backup :
    (state_next != psseq_pkg::ST_NOPWR);
  wire osc_next = (state_next != psseq_pkg::ST_NOPWR);
  wire func_rst_next = (state_next == psseq_pkg::ST_NOPWR) ||
    (state_next == psseq_pkg::ST_BACKUP);
  // Boost converter never takes a slot: software enable, on state only
  wire boost_next = (state_next == psseq_pkg::ST_ON) && cfg_i.boost_sw_en;
  wire [15:0] status_next = 16'(state_next) << psseq_pkg::STATE_LSB;

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg <= psseq_pkg::ST_OFF;
      slot_reg <= psseq_pkg::SLOT_FIRST;
      cnt_reg <= '0;
      fail_cnt_reg <= '0;
      en_reg <= '0;
      fail_reg <= 1'b0;
      evt_prev_reg <= '0;
      trans_reg <= '0;
    end else begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      cnt_reg <= cnt_next;
      fail_cnt_reg <= fail_cnt_next;
      en_reg <= en_next;
      fail_reg <= fail_next;
      evt_prev_reg <= evt_s;
      trans_reg <= trans_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      boost_reg <= 1'b0;
      reset_out_n_reg <= 1'b0;
      rtc_run_reg <= 1'b1;
      osc_run_reg <= 1'b1;
      func_reset_reg <= 1'b0;
      status_reg <= psseq_pkg::SYSTEM_STATUS_RESET;
    end else begin
      boost_reg <= boost_next;
      reset_out_n_reg <= rst_out_next;
      rtc_run_reg <= rtc_next;
      osc_run_reg <= osc_next;
      func_reset_reg <= func_rst_next;
      status_reg <= status_next;
    end
  end

  assign item_en_o = en_reg;
  assign boost_en_o = boost_reg;
  assign reset_out_n_o = reset_out_n_reg;
  assign rtc_run_o = rtc_run_reg;
  assign osc_run_o = osc_run_reg;
  assign func_reset_o = func_reset_reg;
  assign system_status_o = status_reg;
  assign trans_o = trans_reg;
  assign seq_fail_o = fail_reg;

endmodule

/* File: verif/psseq_reg_model.sv */
`timescale 1ns/10ps

module psseq_reg_model (
  // Clock
  input wire logic clk_i,
  // Enables in, power good out
  input wire logic [psseq_pkg::NITEM-1:0] item_en_i,
  input wire logic [7:0] lag_i,
  input wire logic [psseq_pkg::NITEM-1:0] stuck_i,
  output logic [psseq_pkg::NITEM-1:0] pgood_o
);
  logic [7:0] ramp [psseq_pkg::NITEM];

  initial pgood_o = '0;
  // Good only after lag_i enabled cycles; a stuck item never comes up
  always @(posedge clk_i) begin
    for (int i = 0; i < psseq_pkg::NITEM; i++) begin
      ramp[i] <= !item_en_i[i] ? 8'h00 : (ramp[i] == lag_i ? lag_i : ramp[i] + 8'h01);
      pgood_o[i] <= item_en_i[i] && ramp[i] == lag_i && !stuck_i[i];
    end
  end
endmodule

/* File: verif/psseq_top_properties.sv */
`timescale 1ns/10ps

module psseq_top_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Watched inputs
  input wire psseq_pkg::psseq_supply_t supply_i,
  input wire psseq_pkg::psseq_cfg_t cfg_i,
  // Watched outputs
  input wire logic [psseq_pkg::NITEM-1:0] item_en_o,
  input wire logic boost_en_o,
  input wire logic reset_out_n_o,
  input wire logic rtc_run_o,
  input wire logic func_reset_o,
  input wire logic [15:0] system_status_o,
  input wire psseq_pkg::psseq_trans_t trans_o,
  input wire logic seq_fail_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic [4:0] st = system_status_o[4:0];

  a_status_pad_zero: assert property (system_status_o[15:5] == 11'h000)
    else $error("status upper bits not zero");
  a_on_flag_state: assert property (trans_o.on |-> st == 5'h1F && reset_out_n_o)
    else $error("on flag without on state");
  a_sleep_flag_state: assert property (trans_o.sleep |-> st == 5'h1C)
    else $error("sleep flag without sleep state");
  a_flag_single: assert property (trans_o != 4'h0 |=> trans_o == 4'h0)
    else $error("transition flag longer than one cycle");
  a_off_reset_low: assert property (st == 5'h00 |-> !reset_out_n_o)
    else $error("reset pin high in off");
  a_off_regs_down: assert property (st == 5'h00 [*2] |->
    (item_en_o & ~psseq_pkg::OFFREG_MASK) == 16'h0000 && !boost_en_o)
    else $error("item enabled in off");
  a_backup_dark: assert property (st == 5'h02 [*2] |-> item_en_o == 16'h0000 &&
    func_reset_o && rtc_run_o == !cfg_i.unclocked_backup)
    else $error("backup state not dark");
  a_nopwr_follow: assert property (!supply_i.por_ok [*6] |-> st == 5'h01)
    else $error("no power state not taken");
  a_backup_follow: assert property ((supply_i.por_ok && !supply_i.dev_ok) [*6] |->
    st == 5'h02)
    else $error("backup state not taken");
  a_sleep_exit: assert property (st == 5'h1C ##1 st != 5'h1C |->
    st inside {5'h00, 5'h01, 5'h02, 5'h16})
    else $error("sleep left through a sequence");
  a_fail_dark: assert property ($rose(seq_fail_o) |->
    ##[0:1] (item_en_o == 16'h0000 && st == 5'h00))
    else $error("failure did not force off");
  a_boost_on_only: assert property (boost_en_o |-> st == 5'h1F)
    else $error("boost enabled outside on");
endmodule

bind psseq_top psseq_top_properties u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .supply_i(supply_i), .cfg_i(cfg_i),
  .item_en_o(item_en_o), .boost_en_o(boost_en_o), .reset_out_n_o(reset_out_n_o),
  .rtc_run_o(rtc_run_o), .func_reset_o(func_reset_o), .system_status_o(system_status_o),
  .trans_o(trans_o), .seq_fail_o(seq_fail_o)
);

/* File: verif/tb_psseq_top.sv */
`timescale 1ns/10ps

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end

module tb_psseq_top;
  localparam int SLOT_C = 8;
  logic clk_i, reset_n_i;
  psseq_pkg::psseq_supply_t supply;
  psseq_pkg::psseq_cfg_t cfg;
  psseq_pkg::psseq_slots_t on_slot, sleep_slot;
  logic [5:0] evt;
  logic [15:0] sw_en, pgood, stuck, item_en_o, system_status_o, prev_en;
  logic [7:0] lag;
  logic boost_en_o, reset_out_n_o, rtc_run_o, osc_run_o, func_reset_o, seq_fail_o;
  psseq_pkg::psseq_trans_t trans_o;
  int checks, miscompares, cyc, n, d, seed;
  int t_on [16];
  int t_off [16];
  logic [3:0] trans_q [$];
  logic [31:0] r;
  // Flags expected over on, sleep, wake, sleep and off from sleep
  logic [3:0] d_list [5] = '{4'h2, 4'h4, 4'h2, 4'h4, 4'h1};

  psseq_top #(.SLOT_CYCLES(SLOT_C), .DLY_SHORT_CYCLES(4), .DLY_LONG_CYCLES(12),
    .FAIL_CYCLES(200)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .supply_i(supply),
    .evt_i(psseq_pkg::psseq_evt_t'(evt)), .pgood_i(pgood), .cfg_i(cfg),
    .on_slot_i(on_slot), .sleep_slot_i(sleep_slot), .sw_en_i(sw_en),
    .item_en_o(item_en_o), .boost_en_o(boost_en_o), .reset_out_n_o(reset_out_n_o),
    .rtc_run_o(rtc_run_o), .osc_run_o(osc_run_o), .func_reset_o(func_reset_o),
    .system_status_o(system_status_o), .trans_o(trans_o), .seq_fail_o(seq_fail_o));
  psseq_reg_model u_regs (.clk_i(clk_i), .item_en_i(item_en_o), .lag_i(lag),
    .stuck_i(stuck), .pgood_o(pgood));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////
  // Edge times and flag history seen at the ports
  always @(negedge clk_i) begin
    cyc++;
    for (int i = 0; i < 16; i++) begin
      if (item_en_o[i] && !prev_en[i]) t_on[i] = cyc;
      if (!item_en_o[i] && prev_en[i]) t_off[i] = cyc;
    end
    prev_en = item_en_o;
    if (trans_o != 4'h0) trans_q.push_back(trans_o);
    if (cyc > 6000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic ev(input int b, input logic v);
    @(posedge clk_i);
    evt[b] <= v;
  endtask

  task automatic wait_st(input logic [4:0] code, input int lim);
    n = 0;
    while (system_status_o[4:0] !== code && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(system_status_o[4:0], code)
  endtask

  task automatic expect_trans(input logic [3:0] v);
    logic [3:0] got;
    got = (trans_q.size() == 0) ? 4'h0 : trans_q.pop_front();
    `CHK(got, v)
  endtask

  function automatic logic [15:0] used(input psseq_pkg::psseq_slots_t t);
    for (int i = 0; i < 16; i++) used[i] = t[i] != 3'h0;
  endfunction

  // Lower slot acts first unless rev; equal slots are not ordered
  task automatic check_order(input psseq_pkg::psseq_slots_t t, input bit up, input bit rev);
    int a, b;
    for (int i = 0; i < 16; i++)
      for (int j = 0; j < 16; j++)
        if (t[i] != 3'h0 && t[i] < t[j]) begin
          a = up ? t_on[i] : t_off[i];
          b = up ? t_on[j] : t_off[j];
          `CHK(rev ? a > b : a < b, 1'b1)
        end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    seed = 82369;
    reset_n_i = 1'b0;
    supply = 3'b111;
    cfg = 5'b10001;
    evt = 6'h00;
    lag = 8'h02;
    stuck = 16'h0000;
    sw_en = 16'h2000;
    prev_en = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      on_slot[i] = (i == 13) ? 3'h0 : 3'(i % 5 + 1);
      sleep_slot[i] = (i < 10 || i == 14) ? 3'((i + 2) % 5 + 1) : 3'h0;
    end
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    `CHK(system_status_o, 16'h0000)
    `CHK({reset_out_n_o, rtc_run_o, item_en_o}, 18'h10000)
    supply.sys_ok <= 1'b0;
    ev(0, 1'b1);
    repeat (12) @(posedge clk_i);
    `CHK(system_status_o, 16'h0000)
    ev(0, 1'b0);
    supply.sys_ok <= 1'b1;
    ev(4, 1'b1);
    wait_st(5'h0B, 10);
    ev(5, 1'b1);
    wait_st(5'h00, 10);
    expect_trans(4'h1);
    ev(4, 1'b0);
    ev(5, 1'b0);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      cfg <= {2'(k), k[0], 1'b0, r[16]};
      sw_en <= r[15:0] | 16'h2000;
      lag <= (k == 3) ? 8'h0E : 8'h02;
      on_slot[0] <= 3'h1;
      ev(0, 1'b1);
      wait_st(5'h10, 10);
      ev(1, 1'b1);
      wait_st(5'h1F, 300);
      `CHK(n >= ((k == 3) ? 70 : 5 * SLOT_C - 1) && n < 150, 1'b1)
      repeat (6) @(posedge clk_i);
      `CHK(system_status_o, 16'h001F)
      check_order(on_slot, 1'b1, 1'b0);
      `CHK(item_en_o, used(on_slot) | sw_en)
      `CHK(boost_en_o, cfg.boost_sw_en)
      expect_trans(4'h2);
      on_slot[0] <= 3'h5;
      ev(1, 1'b0);
      ev(0, 1'b0);
      ev(1, 1'b1);
      wait_st(5'h14, 10);
      wait_st(5'h11, 20);
      d = (k < 2) ? 1 : ((k == 2) ? 4 : 12);
      `CHK(n >= d && n <= d + 1, 1'b1)
      `CHK(item_en_o & ~used(on_slot), k[0] ? 16'h2000 : 16'h0000)
      wait_st(5'h00, 300);
      check_order(on_slot, 1'b0, 1'b1);
      `CHK(item_en_o, k[0] ? 16'h2000 : 16'h0000)
      `CHK(reset_out_n_o, 1'b0)
      expect_trans(4'h1);
      ev(1, 1'b0);
    end
    cfg.delay_sel <= 2'h0;
    lag <= 8'h02;
    ev(0, 1'b1);
    wait_st(5'h1F, 300);
    ev(0, 1'b0);
    ev(2, 1'b1);
    wait_st(5'h1C, 300);
    ev(2, 1'b0);
    check_order(sleep_slot, 1'b0, 1'b0);
    `CHK(item_en_o & used(sleep_slot), 16'h0000)
    sleep_slot[0] <= 3'h5;
    ev(3, 1'b1);
    wait_st(5'h1F, 300);
    ev(3, 1'b0);
    check_order(sleep_slot, 1'b1, 1'b1);
    `CHK(item_en_o & used(sleep_slot), used(sleep_slot))
    ev(2, 1'b1);
    wait_st(5'h1C, 300);
    ev(2, 1'b0);
    ev(1, 1'b1);
    wait_st(5'h00, 20);
    `CHK(n <= 5, 1'b1)
    ev(1, 1'b0);
    foreach (d_list[i]) expect_trans(d_list[i]);
    stuck <= 16'h0001;
    ev(0, 1'b1);
    n = 0;
    while (seq_fail_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n >= 200 && seq_fail_o, 1'b1)
    `CHK({system_status_o, item_en_o}, 32'h00000000)
    stuck <= 16'h0000;
    ev(0, 1'b0);
    trans_q.delete();
    cfg.unclocked_backup <= 1'b1;
    supply.dev_ok <= 1'b0;
    wait_st(5'h02, 20);
    repeat (2) @(posedge clk_i);
    `CHK({rtc_run_o, func_reset_o, item_en_o}, 18'h10000)
    expect_trans(4'h8);
    supply.dev_ok <= 1'b1;
    wait_st(5'h00, 20);
    supply.por_ok <= 1'b0;
    wait_st(5'h01, 20);
    `CHK({rtc_run_o, osc_run_o, func_reset_o, item_en_o}, 19'h10000)
    supply.por_ok <= 1'b1;
    wait_st(5'h00, 40);
    close_out();
  end

endmodule
